// ### hw/pair_gate.sv
// Power enable of one function from its select and enable bits and a gating condition
`timescale 1ns/1ns
module pair_gate (
    // Control bits
    input  wire logic sel,
    input  wire logic enable,
    // Gating condition, high when the window or pin allows operation
    input  wire logic allow,
    // Result, high when the function is powered
    output logic      power_on
);
    // Enable at 0 always wins; select at 1 ignores the condition
    assign power_on = enable & (sel | allow);
endmodule : pair_gate

// ### hw/pin_sync.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH  = 3,
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] chain [STAGES];

    // Only the next stage reads each stage; output is the last one
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < STAGES; i++) begin
                chain[i] <= '0;
            end
        end else begin
            chain[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                chain[i] <= chain[i-1];
            end
        end
    end

    assign sync_out = chain[STAGES-1];
endmodule : pin_sync

// ### hw/power_down_control.sv
// Power-down control: register file and per-function power enables
//
// Operation
// [RQ1] Audio test power from one voice bit
// [RQ2] Voice tx and rx each one bit
// [RQ3] Window select 0: window and enable gate
// [RQ4] Enable bit 0 always powers down
// [RQ5] Tx window gates ramp, bb tx, common-mode
// [RQ6] Rx window gates gain control, bb rx
// [RQ7] Pin select 0: sleep pin and enable gate
// [RQ8] Power reg two: dsp port, timing interface
// [RQ9] Aux control one: converters, frequency correction
// [RQ10] Main reference buffers from power reg two pair
// [RQ11] Bandgap: single select, no enable bit
// [RQ12] Current reference follows bandgap control
// [RQ13] Reference buffers off with their function
// [RQ14] Speech buffers, modem rx buffer follow paths
// [RQ15] Common-mode level select bit
// [RQ16] Mic bias level select bit
// [RQ17] Direct bit 1 powers up
// [RQ18] Synchronise window and sleep pins first
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "pwr_ctrl_cfg.svh"
module power_down_control
    import pwr_ctrl_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 10
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // Register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // Window and sleep pins, sleep pin active high
    input  wire logic              TX_WINDOW_PIN,
    input  wire logic              RX_WINDOW_PIN,
    input  wire logic              EXT_SLEEP_PIN,
    // Function power enables, high = powered
    output logic                   AUDIO_TEST_ON,
    output logic                   VOICE_TX_ON,
    output logic                   VOICE_RX_ON,
    output logic                   RAMP_CTRL_ON,
    output logic                   BB_TX_ON,
    output logic                   COMMON_MODE_ON,
    output logic                   GAIN_CTRL_ON,
    output logic                   BB_RX_ON,
    output logic                   DSP_PORT_ON,
    output logic                   TIMING_IF_ON,
    output logic                   AUX_CONV_ON,
    output logic                   FREQ_CORR_ON,
    output logic                   MAIN_REF_ON,
    output logic                   BANDGAP_ON,
    output logic                   CURRENT_REF_ON,
    // Reference buffer enables
    output logic                   SPEECH_TX_BUF_ON,
    output logic                   SPEECH_RX_BUF_ON,
    output logic                   MODEM_RX_BUF_ON,
    output logic                   MIC_BIAS_BUF_ON,
    // Level selects
    output logic                   COMMON_MODE_LEVEL_SEL,
    output logic                   MIC_BIAS_LEVEL
);
    localparam int NFUNC = 11;

    // Software registers
    logic [DATA_W-1:0] voice_config_one;
    logic [DATA_W-1:0] voice_config_two;
    logic [DATA_W-1:0] voice_config_three;
    logic [DATA_W-1:0] power_reg_one;
    logic [DATA_W-1:0] power_reg_two;
    logic [DATA_W-1:0] aux_control_one;
    logic [DATA_W-1:0] aux_control_two;
    logic [DATA_W-1:0] level_select;

    // Synchronised pins
    logic [2:0]        pins_sync;
    logic              tx_window;
    logic              rx_window;
    logic              ext_sleep;

    // Paired-function tables
    logic [NFUNC-1:0]  func_sel;
    logic [NFUNC-1:0]  func_enable;
    logic [NFUNC-1:0]  func_allow;
    logic [NFUNC-1:0]  func_on;
    logic [NFUNC-1:0]  next_on;
    ctrl_src_t         func_src [NFUNC];

    logic [DATA_W-1:0] next_rdata;
    logic              bandgap_allow;

    // Pins may change at any time relative to CLK
    pin_sync #(
        .WIDTH  (3),
        .STAGES (`SYNC_STAGES)
    ) u_pin_sync (
        .clk      (CLK),
        .rst      (SYS_RST),
        .async_in ({EXT_SLEEP_PIN, RX_WINDOW_PIN, TX_WINDOW_PIN}),
        .sync_out (pins_sync)
    ); // [RQ18]

    assign tx_window = pins_sync[0];
    assign rx_window = pins_sync[1];
    assign ext_sleep = pins_sync[2];

    // Register writes
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            voice_config_one   <= `RST_REG;
            voice_config_two   <= `RST_REG;
            voice_config_three <= `RST_REG;
            power_reg_one      <= `RST_REG;
            power_reg_two      <= `RST_REG;
            aux_control_one    <= `RST_REG;
            aux_control_two    <= `RST_REG;
            level_select       <= `RST_REG;
        end else if (WR) begin
            case (ADDR)
                `ADDR_VOICE_CONFIG_ONE:   voice_config_one   <= WDATA;
                `ADDR_VOICE_CONFIG_TWO:   voice_config_two   <= WDATA;
                `ADDR_VOICE_CONFIG_THREE: voice_config_three <= WDATA;
                `ADDR_POWER_REG_ONE:      power_reg_one      <= WDATA;
                `ADDR_POWER_REG_TWO:      power_reg_two      <= WDATA;
                `ADDR_AUX_CONTROL_ONE:    aux_control_one    <= WDATA;
                `ADDR_AUX_CONTROL_TWO:    aux_control_two    <= WDATA;
                `ADDR_LEVEL_SELECT:       level_select       <= WDATA;
                default: ;
            endcase
        end
    end

    // Table of pairs: index, select bit, enable bit, gating source
    always_comb begin
        // 0 ramp controller, tx window
        func_sel[0]    = aux_control_two[`BIT_RAMP_CTRL_WINDOW_SEL];   // [RQ5]
        func_enable[0] = aux_control_two[`BIT_RAMP_CTRL_ENABLE];
        func_src[0]    = CTRL_TX_WINDOW;
        // 1 baseband tx path, tx window
        func_sel[1]    = power_reg_one[`BIT_BB_TX_WINDOW_SEL];         // [RQ5]
        func_enable[1] = power_reg_one[`BIT_BB_TX_ENABLE];
        func_src[1]    = CTRL_TX_WINDOW;
        // 2 common-mode buffers, tx window
        func_sel[2]    = power_reg_one[`BIT_COMMON_MODE_WINDOW_SEL];   // [RQ5]
        func_enable[2] = power_reg_one[`BIT_COMMON_MODE_ENABLE];
        func_src[2]    = CTRL_TX_WINDOW;
        // 3 gain control, rx window
        func_sel[3]    = aux_control_two[`BIT_GAIN_CTRL_WINDOW_SEL];   // [RQ6]
        func_enable[3] = aux_control_two[`BIT_GAIN_CTRL_ENABLE];
        func_src[3]    = CTRL_RX_WINDOW;
        // 4 baseband rx path, rx window
        func_sel[4]    = power_reg_one[`BIT_BB_RX_WINDOW_SEL];         // [RQ6]
        func_enable[4] = power_reg_one[`BIT_BB_RX_ENABLE];
        func_src[4]    = CTRL_RX_WINDOW;
        // 5 dsp serial port, sleep pin
        func_sel[5]    = power_reg_two[`BIT_DSP_PORT_PIN_SEL];         // [RQ8]
        func_enable[5] = power_reg_two[`BIT_DSP_PORT_ENABLE];
        func_src[5]    = CTRL_EXT_SLEEP;
        // 6 timing interface, sleep pin
        func_sel[6]    = power_reg_two[`BIT_TIMING_IF_PIN_SEL];        // [RQ8]
        func_enable[6] = power_reg_two[`BIT_TIMING_IF_ENABLE];
        func_src[6]    = CTRL_EXT_SLEEP;
        // 7 auxiliary converters, sleep pin
        func_sel[7]    = aux_control_one[`BIT_AUX_CONV_PIN_SEL];       // [RQ9]
        func_enable[7] = aux_control_one[`BIT_AUX_CONV_ENABLE];
        func_src[7]    = CTRL_EXT_SLEEP;
        // 8 frequency correction, sleep pin
        func_sel[8]    = aux_control_one[`BIT_FREQ_CORR_PIN_SEL];      // [RQ9]
        func_enable[8] = aux_control_one[`BIT_FREQ_CORR_ENABLE];
        func_src[8]    = CTRL_EXT_SLEEP;
        // 9 main reference and mic bias buffers, sleep pin
        func_sel[9]    = power_reg_two[`BIT_MAIN_REF_PIN_SEL];         // [RQ10]
        func_enable[9] = power_reg_two[`BIT_MAIN_REF_ENABLE];
        func_src[9]    = CTRL_EXT_SLEEP;
        // 10 bandgap: select only, enable held at 1
        func_sel[10]    = power_reg_two[`BIT_BANDGAP_PIN_SEL];         // [RQ11]
        func_enable[10] = 1'b1;                                        // [RQ11]
        func_src[10]    = CTRL_EXT_SLEEP;
    end

    // Each pair is evaluated the same way
    genvar g;
    generate
        for (g = 0; g < NFUNC; g++) begin : g_pair
            always_comb begin
                case (func_src[g])
                    CTRL_TX_WINDOW: func_allow[g] = tx_window;         // [RQ3]
                    CTRL_RX_WINDOW: func_allow[g] = rx_window;         // [RQ3]
                    CTRL_EXT_SLEEP: func_allow[g] = ~ext_sleep;        // [RQ7]
                    default:        func_allow[g] = 1'b1;
                endcase
            end
            pair_gate u_gate (
                .sel      (func_sel[g]),
                .enable   (func_enable[g]),
                .allow    (func_allow[g]),
                .power_on (next_on[g])
            ); // [RQ3] [RQ4] [RQ7]
        end
    endgenerate

    // Enables registered so outputs taken straight from func_on are glitch-free flops
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            func_on <= '0;
        end else begin
            func_on <= next_on;
        end
    end

    // Direct bits, 1 means powered
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            AUDIO_TEST_ON <= 1'b0;
            VOICE_TX_ON   <= 1'b0;
            VOICE_RX_ON   <= 1'b0;
        end else begin
            AUDIO_TEST_ON <= voice_config_three[`BIT_AUDIO_TEST_POWER_ON]; // [RQ1] [RQ17]
            VOICE_TX_ON   <= voice_config_one[`BIT_VOICE_TX_POWER_ON];     // [RQ2] [RQ17]
            VOICE_RX_ON   <= voice_config_two[`BIT_VOICE_RX_POWER_ON];     // [RQ2] [RQ17]
        end
    end

    assign bandgap_allow = func_on[10];

    assign RAMP_CTRL_ON   = func_on[0];
    assign BB_TX_ON       = func_on[1];
    assign COMMON_MODE_ON = func_on[2];
    assign GAIN_CTRL_ON   = func_on[3];
    assign BB_RX_ON       = func_on[4];
    assign DSP_PORT_ON    = func_on[5];
    assign TIMING_IF_ON   = func_on[6];
    assign AUX_CONV_ON    = func_on[7];
    assign FREQ_CORR_ON   = func_on[8];
    assign MAIN_REF_ON    = func_on[9] & bandgap_allow;      // References hang off the bandgap
    assign BANDGAP_ON     = bandgap_allow;                   // [RQ11]
    assign CURRENT_REF_ON = bandgap_allow;                   // [RQ12]

    // Buffers follow what they serve; no software action needed
    assign SPEECH_TX_BUF_ON = MAIN_REF_ON & VOICE_TX_ON;     // [RQ13] [RQ14]
    assign SPEECH_RX_BUF_ON = MAIN_REF_ON & VOICE_RX_ON;     // [RQ13] [RQ14]
    assign MODEM_RX_BUF_ON  = MAIN_REF_ON & BB_RX_ON;        // [RQ13] [RQ14]
    assign MIC_BIAS_BUF_ON  = MAIN_REF_ON & VOICE_TX_ON;     // [RQ13]

    // Level selects straight from the register flops
    assign COMMON_MODE_LEVEL_SEL = level_select[`BIT_COMMON_MODE_LEVEL_SEL];  // [RQ15]
    assign MIC_BIAS_LEVEL        = voice_config_one[`BIT_MIC_BIAS_LEVEL];     // [RQ16]

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        case (ADDR)
            `ADDR_VOICE_CONFIG_ONE:   next_rdata = voice_config_one;
            `ADDR_VOICE_CONFIG_TWO:   next_rdata = voice_config_two;
            `ADDR_VOICE_CONFIG_THREE: next_rdata = voice_config_three;
            `ADDR_POWER_REG_ONE:      next_rdata = power_reg_one;
            `ADDR_POWER_REG_TWO:      next_rdata = power_reg_two;
            `ADDR_AUX_CONTROL_ONE:    next_rdata = aux_control_one;
            `ADDR_AUX_CONTROL_TWO:    next_rdata = aux_control_two;
            `ADDR_LEVEL_SELECT:       next_rdata = level_select;
            `ADDR_POWER_STATUS:       next_rdata = DATA_W'(func_on[NFUNC-2:0]);
            `ADDR_PIN_STATUS:         next_rdata = {{(DATA_W-3){1'b0}}, pins_sync};
            default:                  next_rdata = '0;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= '0;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= '0;
        end
    end
endmodule : power_down_control

// ### hw/pwr_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the power-down control block
`ifndef PWR_CTRL_CFG_SVH
`define PWR_CTRL_CFG_SVH

// Register offsets (word addresses on the plain register port)
`define ADDR_VOICE_CONFIG_ONE   4'h0
`define ADDR_VOICE_CONFIG_TWO   4'h1
`define ADDR_VOICE_CONFIG_THREE 4'h2
`define ADDR_POWER_REG_ONE      4'h3
`define ADDR_POWER_REG_TWO      4'h4
`define ADDR_AUX_CONTROL_ONE    4'h5
`define ADDR_AUX_CONTROL_TWO    4'h6
`define ADDR_LEVEL_SELECT       4'h7
`define ADDR_POWER_STATUS       4'h8
`define ADDR_PIN_STATUS         4'h9

// Field positions
`define BIT_VOICE_TX_POWER_ON      0
`define BIT_MIC_BIAS_LEVEL         1
`define BIT_VOICE_RX_POWER_ON      0
`define BIT_AUDIO_TEST_POWER_ON    0
`define BIT_BB_TX_WINDOW_SEL       0
`define BIT_BB_TX_ENABLE           1
`define BIT_BB_RX_WINDOW_SEL       2
`define BIT_BB_RX_ENABLE           3
`define BIT_COMMON_MODE_WINDOW_SEL 4
`define BIT_COMMON_MODE_ENABLE     5
`define BIT_DSP_PORT_PIN_SEL       0
`define BIT_DSP_PORT_ENABLE        1
`define BIT_TIMING_IF_PIN_SEL      2
`define BIT_TIMING_IF_ENABLE       3
`define BIT_MAIN_REF_PIN_SEL       4
`define BIT_MAIN_REF_ENABLE        5
`define BIT_BANDGAP_PIN_SEL        6
`define BIT_AUX_CONV_PIN_SEL       0
`define BIT_AUX_CONV_ENABLE        1
`define BIT_FREQ_CORR_PIN_SEL      2
`define BIT_FREQ_CORR_ENABLE       3
`define BIT_RAMP_CTRL_WINDOW_SEL   0
`define BIT_RAMP_CTRL_ENABLE       1
`define BIT_GAIN_CTRL_WINDOW_SEL   2
`define BIT_GAIN_CTRL_ENABLE       3
`define BIT_COMMON_MODE_LEVEL_SEL  0

// Reset values: every bit and select at 0, so all but the bandgap and current reference are powered down
`define RST_REG 10'h000

// Synchroniser length in flip-flops
`define SYNC_STAGES 2

`endif

// ### hw/pwr_ctrl_pkg.sv
// Types shared by the power-down control block
package pwr_ctrl_pkg;
    // Which condition besides the enable bit may power a function down
    typedef enum logic [1:0] {
        CTRL_DIRECT,
        CTRL_TX_WINDOW,
        CTRL_RX_WINDOW,
        CTRL_EXT_SLEEP
    } ctrl_src_t;
endpackage : pwr_ctrl_pkg

// ### verification/burst_timer.sv
// Burst timing partner: opens radio windows and drives the sleep pin
`timescale 1ns/1ns
module burst_timer #(
    parameter int LEN = 20
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Requests from the bench
    input  wire logic tx_go,
    input  wire logic rx_go,
    input  wire logic sleep_req,
    // Pins towards the block
    output logic      tx_pin,
    output logic      rx_pin,
    output logic      sleep_pin
);
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;

    // Windows close by themselves, so a lost pulse cannot keep a path powered
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_cnt <= 8'h00;
            rx_cnt <= 8'h00;
        end else begin
            tx_cnt <= tx_go ? 8'(LEN) : (tx_cnt != 8'h00) ? tx_cnt - 8'h01 : 8'h00;
            rx_cnt <= rx_go ? 8'(LEN) : (rx_cnt != 8'h00) ? rx_cnt - 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        sleep_pin <= rst ? 1'b0 : sleep_req;
    end

    assign tx_pin = (tx_cnt != 8'h00);
    assign rx_pin = (rx_cnt != 8'h00);
endmodule : burst_timer

// ### verification/power_down_control_monitor.sv
// Checker for the power-down control ports
`timescale 1ns/1ns
module pdc_monitor #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 10
) (
    // Clock and reset
    input wire logic              CLK,
    input wire logic              SYS_RST,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    // Enables and the mic bias level select
    input wire logic              AUDIO_TEST_ON,
    input wire logic              VOICE_TX_ON,
    input wire logic              VOICE_RX_ON,
    input wire logic              BB_TX_ON,
    input wire logic              BB_RX_ON,
    input wire logic              MAIN_REF_ON,
    input wire logic              BANDGAP_ON,
    input wire logic              CURRENT_REF_ON,
    input wire logic              SPEECH_TX_BUF_ON,
    input wire logic              SPEECH_RX_BUF_ON,
    input wire logic              MODEM_RX_BUF_ON,
    input wire logic              MIC_BIAS_BUF_ON,
    input wire logic              MIC_BIAS_LEVEL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    spch_tx_buf_a: assert property (SPEECH_TX_BUF_ON == (MAIN_REF_ON && VOICE_TX_ON))
        else $error("speech tx buffer wrong");
    spch_rx_buf_a: assert property (SPEECH_RX_BUF_ON == (MAIN_REF_ON && VOICE_RX_ON))
        else $error("speech rx buffer wrong");
    modem_buf_a: assert property (MODEM_RX_BUF_ON == (MAIN_REF_ON && BB_RX_ON))
        else $error("modem rx buffer wrong");
    mic_buf_a: assert property (MIC_BIAS_BUF_ON == (MAIN_REF_ON && VOICE_TX_ON))
        else $error("mic bias buffer wrong");
    cur_ref_a: assert property (CURRENT_REF_ON == BANDGAP_ON)
        else $error("current reference differs from bandgap");
    ref_chain_a: assert property (MAIN_REF_ON |-> BANDGAP_ON)
        else $error("main reference on without bandgap");
    audio_bit_a: assert property (WR && ADDR == 4'h2 |-> ##2 AUDIO_TEST_ON == $past(WDATA[0], 2))
        else $error("audio test power wrong");
    voice_tx_a: assert property (WR && ADDR == 4'h0 |-> ##2 VOICE_TX_ON == $past(WDATA[0], 2))
        else $error("voice tx power wrong");
    voice_rx_a: assert property (WR && ADDR == 4'h1 |-> ##2 VOICE_RX_ON == $past(WDATA[0], 2))
        else $error("voice rx power wrong");
    bb_tx_off_a: assert property (WR && ADDR == 4'h3 && !WDATA[1] |-> ##2 !BB_TX_ON)
        else $error("bb tx on with enable clear");
    bb_rx_sel_a: assert property (WR && ADDR == 4'h3 && WDATA[3:2] == 2'b11 |-> ##2 BB_RX_ON)
        else $error("bb rx off with select and enable set");
    mic_level_a: assert property (WR && ADDR == 4'h0 |-> ##2 MIC_BIAS_LEVEL == $past(WDATA[1], 2))
        else $error("mic bias level wrong");
    rd_idle_a: assert property (!$past(RD) |-> RDATA == '0)
        else $error("read data outside read slot");
endmodule : pdc_monitor

bind power_down_control pdc_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (
    .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .AUDIO_TEST_ON(AUDIO_TEST_ON), .VOICE_TX_ON(VOICE_TX_ON),
    .VOICE_RX_ON(VOICE_RX_ON), .BB_TX_ON(BB_TX_ON), .BB_RX_ON(BB_RX_ON),
    .MAIN_REF_ON(MAIN_REF_ON), .BANDGAP_ON(BANDGAP_ON), .CURRENT_REF_ON(CURRENT_REF_ON),
    .SPEECH_TX_BUF_ON(SPEECH_TX_BUF_ON), .SPEECH_RX_BUF_ON(SPEECH_RX_BUF_ON),
    .MODEM_RX_BUF_ON(MODEM_RX_BUF_ON), .MIC_BIAS_BUF_ON(MIC_BIAS_BUF_ON),
    .MIC_BIAS_LEVEL(MIC_BIAS_LEVEL));

// ### verification/test_power_down_control.sv
// Self-checking bench for the power-down control block
`timescale 1ns/1ns
module test_power_down_control;
    localparam int LEN = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [9:0]  wdata = 10'h000;
    logic [9:0]  rdata;
    logic [20:0] pwr;
    logic        tx_pin, rx_pin, sleep_pin;
    logic        tx_go = 1'b0;
    logic        rx_go = 1'b0;
    logic        sleep_req = 1'b0;
    logic        s, e, p, x, y;
    int          n_errors = 0;
    int          total_checks = 0;

    always #5 clk = ~clk;

    burst_timer #(.LEN(LEN)) timer_u (.clk(clk), .rst(rst), .tx_go(tx_go), .rx_go(rx_go),
        .sleep_req(sleep_req), .tx_pin(tx_pin), .rx_pin(rx_pin), .sleep_pin(sleep_pin));

    power_down_control dut_u (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .TX_WINDOW_PIN(tx_pin), .RX_WINDOW_PIN(rx_pin),
        .EXT_SLEEP_PIN(sleep_pin), .AUDIO_TEST_ON(pwr[0]), .VOICE_TX_ON(pwr[1]),
        .VOICE_RX_ON(pwr[2]), .RAMP_CTRL_ON(pwr[3]), .BB_TX_ON(pwr[4]),
        .COMMON_MODE_ON(pwr[5]), .GAIN_CTRL_ON(pwr[6]), .BB_RX_ON(pwr[7]),
        .DSP_PORT_ON(pwr[8]), .TIMING_IF_ON(pwr[9]), .AUX_CONV_ON(pwr[10]),
        .FREQ_CORR_ON(pwr[11]), .MAIN_REF_ON(pwr[12]), .BANDGAP_ON(pwr[13]),
        .CURRENT_REF_ON(pwr[14]), .SPEECH_TX_BUF_ON(pwr[15]), .SPEECH_RX_BUF_ON(pwr[16]),
        .MODEM_RX_BUF_ON(pwr[17]), .MIC_BIAS_BUF_ON(pwr[18]),
        .COMMON_MODE_LEVEL_SEL(pwr[19]), .MIC_BIAS_LEVEL(pwr[20]));

    task automatic check(input logic [20:0] g, input logic [20:0] x_exp);
        total_checks++;
        if (g !== x_exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x_exp);
        end
    endtask : check

    task automatic wreg(input logic [3:0] a, input logic [9:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [9:0] x_exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(21'(rdata), 21'(x_exp));
    endtask : rreg

    // Pins need three edges through the synchroniser, writes two
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #200_000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle();
        check(pwr, 21'h0_6000);
        for (int a = 0; a < 8; a++) begin
            rreg(4'(a), 10'h000);
        end
        wreg(4'hA, 10'h3FF);
        rreg(4'hA, 10'h000);
        wreg(4'h0, 10'h001);
        wreg(4'h1, 10'h001);
        wreg(4'h2, 10'h001);
        settle();
        check(21'(pwr[2:0]), 21'h0_0007);
        rreg(4'h2, 10'h001);
        for (int k = 0; k < 8; k++) begin
            s = k[0];
            e = k[1];
            p = k[2];
            if (p) begin
                tx_go <= 1'b1;
                rx_go <= 1'b1;
                @(posedge clk);
                tx_go <= 1'b0;
                rx_go <= 1'b0;
            end
            wreg(4'h3, {4'h0, e, s, e, s, e, s});
            wreg(4'h6, {6'h00, e, s, e, s});
            settle();
            x = e & (s | p);
            check(21'(pwr[7:3]), {16'h0000, {5{x}}});
            repeat (LEN) @(posedge clk);
        end
        wreg(4'h3, 10'h00C);
        for (int k = 0; k < 8; k++) begin
            s = k[0];
            e = k[1];
            p = k[2];
            sleep_req <= p;
            wreg(4'h4, {3'h0, s, e, s, e, s, e, s});
            wreg(4'h5, {6'h00, e, s, e, s});
            settle();
            x = e & (s | !p);
            y = s | !p;
            check(21'(pwr[18:8]), {10'h000, {4{x}}, {2{y}}, {5{x}}});
        end
        sleep_req <= 1'b0;
        rreg(4'h4, 10'h07F);
        rreg(4'h5, 10'h00F);
        wreg(4'h1, 10'h000);
        settle();
        check(21'(pwr[17:15]), 21'h0_0005);
        for (int v = 1; v >= 0; v--) begin
            wreg(4'h7, 10'(v));
            wreg(4'h0, 10'(2 * v + 1));
            settle();
            check(21'(pwr[20:19]), 21'(3 * v));
            rreg(4'h7, 10'(v));
        end
        rreg(4'h8, 10'h3F9);
        rreg(4'h9, 10'h000);
        print_verdict();
    end
endmodule : test_power_down_control
